// file: hw/ifr_defs.svh
// constants of the input function router: offsets, resets, fields, timing
// assumes inclusion by bare name from the router's design files
`ifndef IFR_DEFS_SVH
`define IFR_DEFS_SVH

// register byte offsets
`define IFR_OFS_MAP_A    8'h00
`define IFR_OFS_MAP_B    8'h04
`define IFR_OFS_MAP_C    8'h08
`define IFR_OFS_MAP_D    8'h0c
`define IFR_OFS_MAP_E    8'h10
`define IFR_OFS_CONTACTS 8'h14
`define IFR_OFS_FUNCS    8'h18
`define IFR_OFS_CTRL     8'h1c

// reset values
`define IFR_RST_MAP_A    16'h4321
`define IFR_RST_MAP_B    16'h8765
`define IFR_RST_MAP_C    16'h00a9
`define IFR_RST_MAP_D    16'h0000
`define IFR_RST_MAP_E    16'h0000
`define IFR_RST_VIEW     1'b1

// fields and sizes
`define IFR_CTRL_VIEW_BIT 0
`define IFR_MAP_W         16
`define IFR_NUM_MAPS      5
`define IFR_NUM_CONTACTS  10
`define IFR_NUM_FUNCS     20

// digit codes
`define IFR_DIG_NONE   4'h0
`define IFR_DIG_FIRST  4'h1
`define IFR_DIG_LAST   4'ha
`define IFR_DIG_ALWAYS 4'hf

// timing
`define IFR_CLK_KHZ         25000
`define IFR_POS_RST_HOLD_MS 500

`endif

// file: hw/ifr_pkg.sv
// types and the digit decode of the input function router
// assumes the constants header is on the include path
`include "ifr_defs.svh"

package ifr_pkg;

  typedef logic [3:0] ifr_digit_t;
  typedef logic [`IFR_NUM_CONTACTS-1:0] ifr_contacts_t;

  // function positions, digit by digit through the five maps
  typedef enum logic [4:0] {
    IFR_F_SERVO_ON = 5'h00, IFR_F_SPEED_1 = 5'h01,
    IFR_F_SPEED_2 = 5'h02, IFR_F_SPEED_3 = 5'h03,
    IFR_F_ALARM_CLEAR = 5'h04, IFR_F_DIRECTION = 5'h05,
    IFR_F_FWD_LIMIT = 5'h06, IFR_F_REV_LIMIT = 5'h07,
    IFR_F_EMERGENCY_HALT = 5'h08, IFR_F_STOP = 5'h09,
    IFR_F_GEAR_1 = 5'h0a, IFR_F_GEAR_2 = 5'h0b,
    IFR_F_PROP_ONLY = 5'h0c, IFR_F_GAIN_2 = 5'h0d,
    IFR_F_ERR_CLEAR = 5'h0e, IFR_F_TORQUE_LIMIT = 5'h0f,
    IFR_F_MODE_CHANGE = 5'h10, IFR_F_POS_REQUEST = 5'h11,
    IFR_F_ZERO_HOLD = 5'h12, IFR_F_POS_RESET = 5'h13
  } ifr_func_t;

  // state of one function given its digit and the contacts
  function automatic logic ifr_pick(input ifr_digit_t d,
                                    input ifr_contacts_t c);
    logic r;
    // RULE9 RULE13 default unconnected
    r = 1'b0;
    // RULE5 RULE12 contact or forced
    if (d >= `IFR_DIG_FIRST && d <= `IFR_DIG_LAST) begin
      r = c[4'(d - `IFR_DIG_FIRST)];
    end else if (d == `IFR_DIG_ALWAYS) begin
      r = 1'b1;
    end
    return r;
  endfunction

endpackage

// file: hw/ifr_route.sv
// routing of every function onto the contact that its digit names
// assumes contacts already synchronised to hclk
`timescale 1ns/1ps
`include "ifr_defs.svh"

module ifr_route (
  // allocation maps
  input  logic [`IFR_MAP_W-1:0]        map_a,
  input  logic [`IFR_MAP_W-1:0]        map_b,
  input  logic [`IFR_MAP_W-1:0]        map_c,
  input  logic [`IFR_MAP_W-1:0]        map_d,
  input  logic [`IFR_MAP_W-1:0]        map_e,
  // contact states
  input  logic [`IFR_NUM_CONTACTS-1:0] contacts,
  // routed function states
  output logic [`IFR_NUM_FUNCS-1:0]    funcs
);

  wire [`IFR_MAP_W*`IFR_NUM_MAPS-1:0] all_digits;

  // digit 1 in the low nibble
  assign all_digits = {map_e, map_d, map_c, map_b, map_a};

  genvar i;
  generate
    for (i = 0; i < `IFR_NUM_FUNCS; i++) begin : g_func
      // RULE3 each function alone
      assign funcs[i] = ifr_pkg::ifr_pick(all_digits[4*i +: 4], contacts);
    end
  endgenerate

endmodule

// file: hw/ifr_top.sv
// input function router: ahb-lite registers, contact sync, routing, display
// assumes a single ahb-lite master, contacts straight from connector pins
//
// What this block does
// RULE1 - contact ten shows leftmost, contact one rightmost on the indicator.
// RULE2 - with status view selected, indicator follows each contact's state.
// RULE3 - twenty functions, each routed independently onto ten contacts.
// RULE4 - one nibble per function in five maps, digit one lowest.
// RULE5 - digit 1 to 9 picks contacts one to nine, A picks ten.
// RULE6 - several digits may name one contact; all follow it together.
// RULE7 - writing a map changes routing at once, no commit needed.
// RULE8 - software should turn off parameter saving before changing maps.
// RULE9 - digit 0 leaves the function unconnected and never asserted.
// RULE10 - position data reset fires only after 500 ms held high.
// RULE11 - reset maps give the default contact order of functions.
// RULE12 - digit F holds the function asserted regardless of contacts.
// RULE13 - digits B to E act as unconnected, like 0.
`timescale 1ns/1ps
`include "ifr_defs.svh"

module ifr_top #(
  parameter logic [23:0] POS_RST_HOLD_CYC =
    24'(`IFR_POS_RST_HOLD_MS * `IFR_CLK_KHZ)
) (
  // clock and reset
  input  logic                         hclk,
  input  logic                         hresetn,
  // ahb-lite slave
  input  logic                         hsel,
  input  logic [31:0]                  haddr,
  input  logic [1:0]                   htrans,
  input  logic                         hwrite,
  input  logic [2:0]                   hsize,
  input  logic [31:0]                  hwdata,
  input  logic                         hready,
  output logic                         hreadyout,
  output logic [31:0]                  hrdata,
  output logic                         hresp,
  // contact pins
  input  logic [`IFR_NUM_CONTACTS-1:0] input_contact,
  // function outputs
  output logic [`IFR_NUM_FUNCS-1:0]    func_active,
  output logic                         pos_reset_pulse,
  // indicator, bit 9 is contact ten
  output logic [`IFR_NUM_CONTACTS-1:0] disp_led
);

  localparam int NC = `IFR_NUM_CONTACTS;
  localparam int NF = `IFR_NUM_FUNCS;

  // bus phase registers
  logic                   wr_q;
  logic                   wr_d;
  logic                   rd_q;
  logic                   rd_d;
  logic [7:0]             addr_q;
  logic [7:0]             addr_d;
  logic                   hi_ok_q;
  logic                   hi_ok_d;

  // programmable state
  logic [`IFR_MAP_W-1:0]  map_q [0:`IFR_NUM_MAPS-1];
  logic                   view_q;

  // contact synchroniser and settled state
  logic [NC-1:0]          s1_q;
  logic [NC-1:0]          s2_q;
  logic [NC-1:0]          s3_q;
  logic [NC-1:0]          in_q;
  logic [NC-1:0]          in_d;

  // outputs and hold timer
  logic [NF-1:0]          func_q;
  logic [NF-1:0]          func_d;
  logic [NC-1:0]          led_q;
  logic [NC-1:0]          led_d;
  logic [23:0]            hold_q;
  logic [23:0]            hold_d;
  logic                   pulse_q;
  logic                   pulse_d;

  // address and data phase decode, read data, sync agreement and hold timer wires
  wire req_ok;
  wire map_hit;
  wire ctrl_hit;
  wire wr_map;
  wire wr_ctrl;
  wire [2:0] map_idx;
  wire [31:0] rd_mux;
  wire [NC-1:0] agree;
  wire pos_fn;

  assign req_ok = hsel && hready && htrans[1] && hsize == 3'h2;
  assign wr_d = req_ok && hwrite;
  assign rd_d = req_ok && !hwrite;
  assign addr_d = {haddr[7:2], 2'h0};
  assign hi_ok_d = haddr[31:8] == 24'h0;

  // data phase decode of the captured address
  assign map_idx = addr_q[4:2];
  assign map_hit = addr_q <= `IFR_OFS_MAP_E && hi_ok_q;
  assign ctrl_hit = addr_q == `IFR_OFS_CTRL;
  assign wr_map = wr_q && map_hit;
  assign wr_ctrl = wr_q && ctrl_hit;

  // read data: maps, contacts, functions, control, else zero
  assign rd_mux =
    map_hit ? {16'h0, map_q[map_idx]} :
    addr_q == `IFR_OFS_CONTACTS ? {22'h0, in_q} :
    addr_q == `IFR_OFS_FUNCS ? {12'h0, func_q} :
    ctrl_hit ? {31'h0, view_q} : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_q ? rd_mux : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h0;
      hi_ok_q <= 1'b0;
    end else if (hready) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      hi_ok_q <= hi_ok_d;
    end
  end

  // RULE11 default map values
  // RULE7 map writes apply at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      map_q[0] <= `IFR_RST_MAP_A;
      map_q[1] <= `IFR_RST_MAP_B;
      map_q[2] <= `IFR_RST_MAP_C;
      map_q[3] <= `IFR_RST_MAP_D;
      map_q[4] <= `IFR_RST_MAP_E;
    end else if (wr_map) begin
      map_q[map_idx] <= hwdata[`IFR_MAP_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      view_q <= `IFR_RST_VIEW;
    end else if (wr_ctrl) begin
      view_q <= hwdata[`IFR_CTRL_VIEW_BIT];
    end
  end

  // three stage sync, accepted when stages two and three agree
  assign agree = ~(s2_q ^ s3_q);
  assign in_d = (s3_q & agree) | (in_q & ~agree);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      in_q <= '0;
    end else begin
      s1_q <= input_contact;
      s2_q <= s1_q;
      s3_q <= s2_q;
      in_q <= in_d;
    end
  end

  // RULE4 nibble per function
  // RULE6 shared contacts
  ifr_route u_route (
    .map_a    (map_q[0]),
    .map_b    (map_q[1]),
    .map_c    (map_q[2]),
    .map_d    (map_q[3]),
    .map_e    (map_q[4]),
    .contacts (in_q),
    .funcs    (func_d)
  );

  // RULE1 fixed indicator order
  // RULE2 view gates indicator
  assign led_d = view_q ? in_q : '0;

  // RULE10 hold then pulse
  assign pos_fn = func_q[ifr_pkg::IFR_F_POS_RESET];
  assign hold_d = !pos_fn ? 24'h0 :
                  hold_q == POS_RST_HOLD_CYC ? hold_q : hold_q + 24'h1;
  assign pulse_d = pos_fn && hold_q == POS_RST_HOLD_CYC - 24'h1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      func_q <= '0;
      led_q <= '0;
      hold_q <= 24'h0;
      pulse_q <= 1'b0;
    end else begin
      func_q <= func_d;
      led_q <= led_d;
      hold_q <= hold_d;
      pulse_q <= pulse_d;
    end
  end

  assign func_active = func_q;
  assign disp_led = led_q;
  assign pos_reset_pulse = pulse_q;

  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wire [3:0] dig0;
  wire [3:0] dig1;
  wire [3:0] dig5;
  wire [3:0] dig19;

  assign dig0 = map_q[0][3:0];
  assign dig1 = map_q[0][7:4];
  assign dig5 = map_q[1][7:4];
  assign dig19 = map_q[4][15:12];

  property p_led_on;
    view_q |=> disp_led == $past(in_q);
  endproperty
  a_led_on: assert property (p_led_on) // RULE2
    else $error("indicator does not follow contacts");

  property p_led_order;
    view_q |=> disp_led[NC-1] == $past(in_q[NC-1])
      && disp_led[0] == $past(in_q[0]);
  endproperty
  a_led_order: assert property (p_led_order) // RULE1
    else $error("contact ten not on leftmost indicator");

  property p_led_off;
    !view_q |=> disp_led == '0;
  endproperty
  a_led_off: assert property (p_led_off) // RULE2
    else $error("indicator lit with view off");

  property p_unused;
    dig0 == `IFR_DIG_NONE |=> !func_active[0];
  endproperty
  a_unused: assert property (p_unused) // RULE9
    else $error("unconnected function asserted");

  property p_forced;
    dig5 == `IFR_DIG_ALWAYS |=> func_active[5];
  endproperty
  a_forced: assert property (p_forced) // RULE12
    else $error("forced function not asserted");

  property p_reserved;
    dig19 > `IFR_DIG_LAST && dig19 < `IFR_DIG_ALWAYS
      |=> !func_active[NF-1];
  endproperty
  a_reserved: assert property (p_reserved) // RULE13
    else $error("reserved digit asserted function");

  property p_routed;
    dig0 >= `IFR_DIG_FIRST && dig0 <= `IFR_DIG_LAST
      |=> func_active[0] == $past(in_q[4'(dig0 - 4'h1)]);
  endproperty
  a_routed: assert property (p_routed) // RULE5
    else $error("function not on selected contact");

  property p_shared;
    dig0 == dig1 |=> func_active[0] == func_active[1];
  endproperty
  a_shared: assert property (p_shared) // RULE6
    else $error("shared contact functions differ");

  property p_write;
    wr_map && map_idx == 3'h0
      |=> map_q[0] == $past(hwdata[15:0]) ##1
          func_active[0] == ifr_pkg::ifr_pick($past(hwdata[3:0], 2),
                                              $past(in_q));
  endproperty
  a_write: assert property (p_write) // RULE7
    else $error("map write not applied at once");

  property p_pulse_hold;
    pos_reset_pulse |-> $past(hold_q) == POS_RST_HOLD_CYC - 24'h1
      && $past(pos_fn);
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) // RULE10
    else $error("position reset before hold time");

  property p_pulse_low;
    !pos_fn |=> !pos_reset_pulse ##1 !pos_reset_pulse;
  endproperty
  a_pulse_low: assert property (p_pulse_low) // RULE10
    else $error("position reset without held input");

  property p_map_reset;
    $rose(hresetn) |-> map_q[0] == `IFR_RST_MAP_A
      && map_q[1] == `IFR_RST_MAP_B && map_q[2] == `IFR_RST_MAP_C
      && map_q[3] == `IFR_RST_MAP_D && map_q[4] == `IFR_RST_MAP_E;
  endproperty
  a_map_reset: assert property (p_map_reset) // RULE11
    else $error("maps not at default after reset");

  property p_ten_routed;
    dig0 == `IFR_DIG_LAST
      |=> func_active[0] == $past(in_q[NC-1]);
  endproperty
  a_ten_routed: assert property (p_ten_routed) // RULE5
    else $error("digit A not routed to contact ten");

  property p_route_last;
    dig19 >= `IFR_DIG_FIRST && dig19 <= `IFR_DIG_LAST
      |=> func_active[NF-1] == $past(in_q[4'(dig19 - 4'h1)]);
  endproperty
  a_route_last: assert property (p_route_last) // RULE3
    else $error("last function not routed on its own");

  property p_forced_last;
    dig19 == `IFR_DIG_ALWAYS |=> func_active[NF-1];
  endproperty
  a_forced_last: assert property (p_forced_last) // RULE12
    else $error("forced last function not asserted");

  property p_zero_last;
    dig19 == `IFR_DIG_NONE |=> !func_active[NF-1];
  endproperty
  a_zero_last: assert property (p_zero_last) // RULE9
    else $error("unconnected last function asserted");

  property p_view_write;
    wr_ctrl |=> view_q == $past(hwdata[`IFR_CTRL_VIEW_BIT]);
  endproperty
  a_view_write: assert property (p_view_write) // RULE2
    else $error("view select write not applied");

  property p_map_idle;
    !wr_map |=> $stable(map_q[1]);
  endproperty
  a_map_idle: assert property (p_map_idle) // RULE7
    else $error("map changed without a write");

  property p_pulse_once;
    pos_reset_pulse |=> !pos_reset_pulse;
  endproperty
  a_pulse_once: assert property (p_pulse_once) // RULE10
    else $error("position reset pulse longer than one cycle");

endmodule

// file: test/ifr_wiring.sv
// partner model: external control wiring that drives the ten contacts
// assumes the bench sets the wanted levels just after a rising edge
`timescale 1ns/1ps

module ifr_wiring (
  // clock
  input  wire logic       hclk,
  // wanted levels and response speed
  input  wire logic [9:0] want,
  input  wire logic       slow,
  // contact pins
  output logic      [9:0] input_contact
);
  logic [9:0] mid_q;

  initial input_contact = 10'h000;

  always @(posedge hclk) begin
    mid_q         <= want;
    input_contact <= slow ? mid_q : want;
  end
endmodule

// file: test/input_function_router_bench.sv
// bench of the input function router: ahb-lite master, random maps
// assumes the design's assertions sit in its own files
`timescale 1ns/1ps
`include "ifr_defs.svh"

module input_function_router_bench;
  localparam int HOLD = 20;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, pos_reset_pulse, slow = 1'b0;
  logic [9:0]  input_contact, disp_led, want = 10'h000;
  logic [19:0] func_active;
  logic [15:0] m [5];
  int          fail_count = 0, comparisons = 0, cycles = 0, k;
  logic [31:0] seed = 32'd67647;

  always #20 hclk = ~hclk;

  ifr_wiring u_ifr_wiring (.hclk(hclk), .want(want), .slow(slow),
    .input_contact(input_contact));

  ifr_top #(.POS_RST_HOLD_CYC(24'(HOLD))) u_ifr_top (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .input_contact(input_contact), .func_active(func_active),
    .pos_reset_pulse(pos_reset_pulse), .disp_led(disp_led));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected function states from maps and contacts
  function automatic logic [19:0] exp_funcs(input logic [9:0] c);
    logic [19:0] r;
    logic [3:0]  d;
    for (int i = 0; i < 20; i++) begin
      d = m[i / 4][4 * (i % 4) +: 4];
      r[i] = (d == 4'hf) ? 1'b1 :
             (d >= 4'h1 && d <= 4'ha) ? c[d - 4'h1] : 1'b0;
    end
    return r;
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t reg got %h want %h", $time, got, exp);
    end
  endtask

  task automatic check_out(input logic [19:0] got, input logic [19:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t out got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic check_defaults();
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0, rd);
      check_reg(rd, {16'h0, m[i]});
    end
    bus(1'b0, `IFR_OFS_CTRL, 32'h0, rd);
    check_reg(rd, 32'(`IFR_RST_VIEW));
    check_reg({31'h0, hresp}, 32'h0);
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    m = '{16'h4321, 16'h8765, 16'h00a9, 16'h0000, 16'h0000};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    check_defaults();
    bus(1'b0, 8'h3c, 32'h0, rd);
    check_reg(rd, 32'h0);
    bus(1'b1, `IFR_OFS_CTRL, 32'h0, rd);
    bus(1'b0, `IFR_OFS_CTRL, 32'h0, rd);
    check_reg(rd, 32'h0);
    $display("test register defaults done");
    for (int n = 0; n < 40; n++) begin
      for (int i = 0; i < 5; i++) m[i] = 16'(rnd());
      case (n)
        0: m = '{16'h1111, 16'hfefb, 16'h0a0a, 16'hcf00, 16'hc000};
        1: m = '{16'h000a, 16'h0000, 16'h9999, 16'h0000, 16'hf5a0};
        2: m = '{16'h0000, 16'h1234, 16'h5678, 16'h9a00, 16'h3000};
        default: ;
      endcase
      want <= 10'(rnd());
      slow <= n[0];
      bus(1'b1, `IFR_OFS_CTRL, {31'h0, ~n[2]}, rd);
      tick(8);
      check_out(20'(disp_led), n[2] ? 20'h0 : 20'(want));
      for (int i = 0; i < 5; i++) bus(1'b1, 8'(4 * i), rnd() & 32'hffff0000
        | m[i], rd);
      tick(3);
      check_out(func_active, exp_funcs(want));
      bus(1'b0, 8'(4 * (n % 5)), 32'h0, rd);
      check_reg(rd, {16'h0, m[n % 5]});
      bus(1'b0, `IFR_OFS_FUNCS, 32'h0, rd);
      check_reg(rd, {12'h0, exp_funcs(want)});
      bus(1'b0, `IFR_OFS_CONTACTS, 32'h0, rd);
      check_reg(rd, {22'h0, want});
    end
    $display("test random routing done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    m = '{16'h4321, 16'h8765, 16'h00a9, 16'h0000, 16'h0000};
    check_defaults();
    $display("test mid-run reset done");
    m = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1000};
    bus(1'b1, `IFR_OFS_MAP_E, 32'h1000, rd);
    want <= 10'h000;
    tick(8);
    @(posedge hclk);
    want <= 10'h001;
    k = 0;
    while (func_active[19] !== 1'b1 && k < 50) begin
      tick(1);
      k++;
    end
    k = 0;
    while (pos_reset_pulse !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    check_reg(32'(k), 32'(HOLD));
    tick(1);
    check_out(20'(pos_reset_pulse), 20'h0);
    k = 0;
    repeat (HOLD + 5) begin
      tick(1);
      if (pos_reset_pulse === 1'b1) k++;
    end
    @(posedge hclk);
    want <= 10'h000;
    tick(8);
    for (int j = 0; j < 2 * HOLD + 10; j++) begin
      @(posedge hclk);
      want <= (j < HOLD / 2) ? 10'h001 : 10'h000;
      #1;
      if (pos_reset_pulse === 1'b1) k++;
    end
    check_reg(32'(k), 32'h0);
    $display("test position reset hold done");
    report_and_stop();
  end
endmodule
